// File: src/qpsc_pkg.sv
// Constants, types and carriers of the quad predriver serial control block
package qpsc_pkg;

    localparam int unsigned CH_NUM = 4;
    localparam int unsigned SYS_CLK_KHZ = 40000;

    localparam int unsigned FAULT_MASK_TIME_US = 60;
    localparam int unsigned SHORT_DEGLITCH_TIME_US = 8;
    localparam int unsigned RETRY_PULSE_US = 68;
    localparam int unsigned RETRY_PERIOD_MS = 10;

    // Least times, rounded up to whole cycles
    localparam int unsigned MASK_CYC =
        (FAULT_MASK_TIME_US * SYS_CLK_KHZ + 999) / 1000;
    localparam int unsigned DEGLITCH_CYC =
        (SHORT_DEGLITCH_TIME_US * SYS_CLK_KHZ + 999) / 1000;
    localparam int unsigned PULSE_CYC =
        (RETRY_PULSE_US * SYS_CLK_KHZ + 999) / 1000;
    localparam int unsigned PERIOD_CYC = RETRY_PERIOD_MS * SYS_CLK_KHZ;

    localparam int unsigned TMR_W = 12;
    localparam int unsigned PER_W = 19;

    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [3:0] FAULT_RST = 4'h0;

    typedef enum logic [2:0] {
        QPSC_OFF  = 3'b001,
        QPSC_ON   = 3'b010,
        QPSC_TRIP = 3'b100
    } qpsc_ch_state_t;

    typedef struct packed {
        qpsc_ch_state_t state;
        logic [TMR_W-1:0] mask_cnt;
        logic [TMR_W-1:0] dg_cnt;
        logic [PER_W-1:0] per_cnt;
        logic gate;
        logic shorted;
        logic open;
    } qpsc_ch_t;

    // Word and first-edge toggle handed from the serial clock domain
    typedef struct packed {
        logic [3:0] word;
        logic tog;
    } qpsc_link_t;

endpackage

// File: src/qpsc_sync.sv
// Two-flop level synchroniser into the system clock domain
`timescale 1ns/1ps
module qpsc_sync import qpsc_pkg::*; #(
    parameter int unsigned W = 1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } qpsc_sync_t;

    qpsc_sync_t s;
    qpsc_sync_t next_s;

    always_comb begin
        next_s.s1 = d;
        next_s.s2 = s.s1;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.s2;
endmodule

// File: src/qpsc_link.sv
// Serial clock side: shift register and serial output
`timescale 1ns/1ps
module qpsc_link import qpsc_pkg::*; (
    input wire logic sclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic serial_in,
    input wire logic [3:0] fault_snap,
    output qpsc_link_t link,
    output logic serial_out,
    output logic serial_out_oe
);
    typedef struct packed {
        logic [3:0] shreg;
        logic tog;
    } qpsc_lpos_t;

    typedef struct packed {
        logic out_bit;
        logic fell;
    } qpsc_lneg_t;

    qpsc_lpos_t p;
    qpsc_lpos_t next_p;
    logic active;
    qpsc_lneg_t n;
    qpsc_lneg_t next_n;
    logic link_rst;

    // Select high holds the frame flags clear, so any clock then counts as a first edge
    assign link_rst = rst | cs_n;

    always_comb begin
        next_p = p;
        if (!active) begin
            // First edge: fault word was loaded at select fall
            next_p.shreg = {fault_snap[2:0], serial_in};
            next_p.tog = ~p.tog;
        end else begin
            next_p.shreg = {p.shreg[2:0], serial_in};
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            p <= '0;
        end else begin
            p <= next_p;
        end
    end

    always_ff @(posedge sclk or posedge link_rst) begin
        if (link_rst) begin
            active <= 1'b0;
        end else begin
            active <= 1'b1;
        end
    end

    always_comb begin
        next_n.out_bit = p.shreg[3];
        next_n.fell = 1'b1;
    end

    always_ff @(negedge sclk or posedge link_rst) begin
        if (link_rst) begin
            n <= '0;
        end else begin
            n <= next_n;
        end
    end

    assign link.word = p.shreg;
    assign link.tog = p.tog;
    // Before the first fall the fault MSB is shown directly
    assign serial_out = n.fell ? n.out_bit : fault_snap[3];
    assign serial_out_oe = ~cs_n;
endmodule

// File: src/qpsc_top.sv
// Four-channel predriver control: serial link, gate logic, fault detection
`timescale 1ns/1ps
module qpsc_top import qpsc_pkg::*; #(
    parameter bit RETRY_VARIANT = 1'b0,
    parameter int unsigned RETRY_PERIOD_CYC = PERIOD_CYC,
    parameter int unsigned FAULT_MASK_CYC = MASK_CYC,
    parameter int unsigned SHORT_DEGLITCH_CYC = DEGLITCH_CYC,
    parameter int unsigned RETRY_PULSE_CYC = PULSE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    input wire logic [CH_NUM-1:0] direct_channel_in,
    input wire logic [CH_NUM-1:0] drain_sense_in,
    input wire logic over_battery_in,
    output logic [CH_NUM-1:0] fet_drive_out,
    output logic fault_flag_n,
    output logic fault_flag_n_oe
);
    localparam logic [TMR_W-1:0] MASK_LOAD = TMR_W'(FAULT_MASK_CYC - 1);
    localparam logic [TMR_W-1:0] DG_LAST = TMR_W'(SHORT_DEGLITCH_CYC - 1);
    localparam logic [PER_W-1:0] PULSE_END = PER_W'(RETRY_PULSE_CYC);
    localparam logic [PER_W-1:0] PULSE_LAST = PER_W'(RETRY_PULSE_CYC - 1);
    localparam logic [PER_W-1:0] PER_LAST = PER_W'(RETRY_PERIOD_CYC - 1);

    typedef struct packed {
        logic [3:0] ctrl;
        logic [3:0] snap;
        logic cs_q;
        logic tog_seen;
        logic flag_oe;
    } qpsc_sys_t;

    qpsc_sys_t s;
    qpsc_sys_t next_s;

    qpsc_link_t link;
    qpsc_link_t link_sync;
    logic cs_sync;
    logic sel_sync;
    logic [CH_NUM-1:0] direct_sync;
    logic [CH_NUM-1:0] drain_hi;
    logic ovb_sync;
    logic [CH_NUM-1:0] ch_fault;
    logic [CH_NUM-1:0] ch_gate;

    qpsc_link u_link (
        .sclk(sclk),
        .rst(rst),
        .cs_n(cs_n),
        .serial_in(serial_in),
        .fault_snap(s.snap),
        .link(link),
        .serial_out(serial_out),
        .serial_out_oe(serial_out_oe)
    );

    // The word is stable while select is high, so a plain two-flop pass
    // is enough once the synchronised select rise has been seen.
    qpsc_sync #(.W(5)) u_sync_link (
        .clk_sys(clk_sys),
        .rst(rst),
        .d(link),
        .q(link_sync)
    );

    // Select passes inverted so the sync reset value equals its idle level;
    // otherwise reset release looks like a select fall and rise.
    qpsc_sync #(.W(1)) u_sync_cs (
        .clk_sys(clk_sys),
        .rst(rst),
        .d(~cs_n),
        .q(sel_sync)
    );
    assign cs_sync = ~sel_sync;

    qpsc_sync #(.W(CH_NUM)) u_sync_direct (
        .clk_sys(clk_sys),
        .rst(rst),
        .d(direct_channel_in),
        .q(direct_sync)
    );

    qpsc_sync #(.W(CH_NUM)) u_sync_drain (
        .clk_sys(clk_sys),
        .rst(rst),
        .d(drain_sense_in),
        .q(drain_hi)
    );

    qpsc_sync #(.W(1)) u_sync_ovb (
        .clk_sys(clk_sys),
        .rst(rst),
        .d(over_battery_in),
        .q(ovb_sync)
    );

    // Select edges in the system domain: capture faults and latch control
    always_comb begin
        next_s = s;
        next_s.cs_q = cs_sync;
        if (s.cs_q && !cs_sync) begin
            // Faults gone by now are never seen; over-battery kept out
            next_s.snap = ch_fault;
        end
        if (!s.cs_q && cs_sync) begin
            if (link_sync.tog != s.tog_seen) begin
                // Short frames leave fault bits in the word on purpose
                next_s.ctrl = link_sync.word;
            end else begin
                // No clock at all: the loaded fault word is latched
                next_s.ctrl = s.snap;
            end
            next_s.tog_seen = link_sync.tog;
            next_s.snap = FAULT_RST;
        end
        next_s.flag_oe = (|ch_fault) | ovb_sync;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s.ctrl <= CTRL_RST;
            s.snap <= FAULT_RST;
            s.cs_q <= 1'b1;
            s.tog_seen <= 1'b0;
            s.flag_oe <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < CH_NUM; gi = gi + 1) begin : g_ch
            qpsc_ch_t c;
            qpsc_ch_t next_c;
            logic req;
            logic mask_done;

            assign req = direct_sync[gi] | s.ctrl[gi];
            assign mask_done = (c.mask_cnt == '0);

            always_comb begin
                next_c = c;
                case (c.state)
                    QPSC_OFF: begin
                        next_c.gate = 1'b0;
                        // Open load only judged with gate off, past mask
                        next_c.open = mask_done && !drain_hi[gi]
                            && !ovb_sync;
                        if (req && !ovb_sync) begin
                            next_c.state = QPSC_ON;
                            next_c.gate = 1'b1;
                            next_c.open = 1'b0;
                        end
                    end
                    QPSC_ON: begin
                        next_c.open = 1'b0;
                        next_c.gate = 1'b1;
                        if (!req || ovb_sync) begin
                            next_c.state = QPSC_OFF;
                            next_c.gate = 1'b0;
                            next_c.dg_cnt = '0;
                        end else if (mask_done && drain_hi[gi]) begin
                            if (c.dg_cnt == DG_LAST) begin
                                next_c.state = QPSC_TRIP;
                                next_c.shorted = 1'b1;
                                next_c.gate = 1'b0;
                                next_c.dg_cnt = '0;
                                next_c.per_cnt = PULSE_END;
                            end else begin
                                next_c.dg_cnt = c.dg_cnt + 1'b1;
                            end
                        end else begin
                            next_c.dg_cnt = '0;
                        end
                    end
                    QPSC_TRIP: begin
                        if (!req) begin
                            // Commanding the channel off clears the trip
                            next_c.state = QPSC_OFF;
                            next_c.shorted = 1'b0;
                            next_c.gate = 1'b0;
                            next_c.per_cnt = '0;
                        end else if (RETRY_VARIANT && !ovb_sync) begin
                            if (c.per_cnt == PER_LAST) begin
                                next_c.per_cnt = '0;
                            end else begin
                                next_c.per_cnt = c.per_cnt + 1'b1;
                            end
                            next_c.gate = (next_c.per_cnt < PULSE_END);
                            // Pulse outlasts the mask; judge at its end
                            if (c.per_cnt == PULSE_LAST && mask_done
                                && !drain_hi[gi]) begin
                                next_c.state = QPSC_ON;
                                next_c.shorted = 1'b0;
                                next_c.gate = 1'b1;
                                next_c.per_cnt = '0;
                            end
                        end else begin
                            next_c.gate = 1'b0;
                        end
                    end
                    default: begin
                        next_c.state = QPSC_OFF;
                        next_c.gate = 1'b0;
                    end
                endcase
                // Every gate edge restarts the drain mask window
                if (next_c.gate != c.gate) begin
                    next_c.mask_cnt = MASK_LOAD;
                end else if (!mask_done) begin
                    next_c.mask_cnt = c.mask_cnt - 1'b1;
                end
            end

            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    c.state <= QPSC_OFF;
                    // Start masked: the drain sync reads low until it fills
                    c.mask_cnt <= MASK_LOAD;
                    c.dg_cnt <= '0;
                    c.per_cnt <= '0;
                    c.gate <= 1'b0;
                    c.shorted <= 1'b0;
                    c.open <= 1'b0;
                end else begin
                    c <= next_c;
                end
            end

            assign ch_fault[gi] = c.shorted | c.open;
            assign ch_gate[gi] = c.gate;
        end
    endgenerate

    assign fet_drive_out = ch_gate;
    // Open drain: the pin is only ever pulled low
    assign fault_flag_n = 1'b0;
    assign fault_flag_n_oe = s.flag_oe;
endmodule

// File: dv/qpsc_chk.sv
// Port-level checker of the quad predriver serial control block
`timescale 1ns/1ps
module qpsc_chk import qpsc_pkg::*; #(
    parameter int unsigned FAULT_MASK_CYC = MASK_CYC,
    parameter int unsigned SHORT_DEGLITCH_CYC = DEGLITCH_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic [CH_NUM-1:0] direct_channel_in,
    input wire logic [CH_NUM-1:0] drain_sense_in,
    input wire logic over_battery_in,
    input wire logic [CH_NUM-1:0] fet_drive_out,
    input wire logic fault_flag_n,
    input wire logic fault_flag_n_oe
);
    logic [2:0] nrise;
    logic [7:0] s_cnt;
    logic [7:0] o_cnt;
    // Rises seen in this frame; select high clears it like a frame reset
    always_ff @(posedge sclk or posedge cs_n or posedge rst) begin
        if (cs_n || rst) begin
            nrise <= 3'h0;
        end else if (nrise != 3'h7) begin
            nrise <= nrise + 3'h1;
        end
    end
    // Cycles with channel 0 on into a high drain, channel 1 off into a low one
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_cnt <= 8'h00;
            o_cnt <= 8'h00;
        end else begin
            s_cnt <= (fet_drive_out[0] && drain_sense_in[0] &&
                !over_battery_in) ? s_cnt + 8'h01 : 8'h00;
            o_cnt <= (!fet_drive_out[1] && !drain_sense_in[1] &&
                !over_battery_in) ? o_cnt + 8'h01 : 8'h00;
        end
    end
    a_cascade_delay: assert property (@(posedge sclk) disable iff (rst)
        !cs_n && nrise >= 3'h4 |-> serial_out == $past(serial_in, 4))
        else $error("serial out is not serial in four clocks late");
    a_oe_select: assert property (@(posedge clk_sys) disable iff (rst)
        serial_out_oe == !cs_n)
        else $error("serial out enable does not follow select");
    a_flag_pin_low: assert property (@(posedge clk_sys) disable iff (rst)
        fault_flag_n == 1'b0)
        else $error("fault flag pin value is not low");
    a_battery_flag: assert property (@(posedge clk_sys) disable iff (rst)
        over_battery_in [*5] |-> fault_flag_n_oe)
        else $error("over battery does not raise the fault flag");
    a_battery_gates: assert property (@(posedge clk_sys) disable iff (rst)
        over_battery_in [*5] |-> fet_drive_out == 4'h0)
        else $error("over battery leaves a gate on");
    a_short_trip: assert property (@(posedge clk_sys) disable iff (rst)
        s_cnt <= FAULT_MASK_CYC + SHORT_DEGLITCH_CYC + 8)
        else $error("shorted channel gate not switched off in time");
    a_short_mask: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(fet_drive_out[0]) && $past(s_cnt) != 8'h00 &&
        $past(direct_channel_in[0], 3) && !$past(over_battery_in, 3)
        |-> $past(s_cnt) >= FAULT_MASK_CYC)
        else $error("short trip inside the mask interval");
    a_open_flag: assert property (@(posedge clk_sys) disable iff (rst)
        o_cnt > FAULT_MASK_CYC + 6 |-> fault_flag_n_oe)
        else $error("open load not flagged after the mask interval");
    c_cascade: cover property (@(posedge sclk) nrise == 3'h7);
    c_flag: cover property (@(posedge clk_sys) $rose(fault_flag_n_oe));
    c_trip: cover property (@(posedge clk_sys) $fell(fet_drive_out[0]));
endmodule
bind qpsc_top qpsc_chk #(.FAULT_MASK_CYC(FAULT_MASK_CYC),
    .SHORT_DEGLITCH_CYC(SHORT_DEGLITCH_CYC)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .direct_channel_in(direct_channel_in),
    .drain_sense_in(drain_sense_in), .over_battery_in(over_battery_in),
    .fet_drive_out(fet_drive_out), .fault_flag_n(fault_flag_n),
    .fault_flag_n_oe(fault_flag_n_oe));

// File: dv/qpsc_host.sv
// Host model: drives select, serial clock and serial data of the link
`timescale 1ns/1ps
module qpsc_host (
    output logic sclk,
    output logic cs_n,
    output logic serial_in,
    input wire logic serial_out
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_in = 1'b0;
    end
    // Clock stands low between frames and runs at 48 ns inside them
    task automatic xfer(input int n, input logic [7:0] din,
                        output logic [7:0] dout);
        dout = 8'h00;
        cs_n = 1'b0;
        // Long lead-in lets the fault snapshot settle in the system domain
        #200;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = din[i];
            #24;
            dout = {dout[6:0], serial_out};
            sclk = 1'b1;
            #24;
            sclk = 1'b0;
        end
        #24;
        cs_n = 1'b1;
        // Released data line shows the inverse, never the last bit
        serial_in = ~serial_in;
        #200;
    endtask
endmodule

// File: dv/qpsc_top_bench.sv
// Self-checking bench of the quad predriver serial control block
`timescale 1ns/1ps
module qpsc_top_bench;
    import qpsc_pkg::*;
    localparam int MSK = 20;
    localparam int DG = 5;
    localparam int RPULSE = 30;
    localparam int RPER = 3000;
    logic short_r = 1'b0;
    logic [3:0] drain_r, fet_r;
    logic so_r, soe_r, flag_r, flag_r_oe;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic sclk, cs_n, serial_in, serial_out, serial_out_oe;
    logic [3:0] direct_channel_in = 4'h0;
    logic [3:0] drain_sense_in, fet_drive_out;
    logic [3:0] short_m = 4'h0;
    logic [3:0] open_m = 4'h0;
    logic over_battery_in = 1'b0;
    logic fault_flag_n, fault_flag_n_oe;
    logic [7:0] rd;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    // Load model: a healthy drain is high when off and low when on
    assign drain_sense_in = (~fet_drive_out | short_m) & ~open_m;
    assign drain_r = ~fet_r | {3'h0, short_r};
    always #12.5 clk_sys = ~clk_sys;
    qpsc_top #(.RETRY_VARIANT(1'b0), .RETRY_PERIOD_CYC(3000),
        .FAULT_MASK_CYC(MSK), .SHORT_DEGLITCH_CYC(DG),
        .RETRY_PULSE_CYC(30)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs_n(cs_n),
        .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .direct_channel_in(direct_channel_in),
        .drain_sense_in(drain_sense_in), .over_battery_in(over_battery_in),
        .fet_drive_out(fet_drive_out), .fault_flag_n(fault_flag_n),
        .fault_flag_n_oe(fault_flag_n_oe));
    // Retry variant shares the host link, direct and over-battery inputs; its drain has its own load model
    qpsc_top #(.RETRY_VARIANT(1'b1), .RETRY_PERIOD_CYC(RPER),
        .FAULT_MASK_CYC(MSK), .SHORT_DEGLITCH_CYC(DG),
        .RETRY_PULSE_CYC(RPULSE)) u_dut_r (
        .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs_n(cs_n),
        .serial_in(serial_in), .serial_out(so_r),
        .serial_out_oe(soe_r), .direct_channel_in(direct_channel_in),
        .drain_sense_in(drain_r), .over_battery_in(over_battery_in),
        .fet_drive_out(fet_r), .fault_flag_n(flag_r),
        .fault_flag_n_oe(flag_r_oe));
    qpsc_host u_host (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
        .serial_out(serial_out));
    task automatic chk(input string name, input logic [3:0] seen,
                       input logic [3:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, seen);
            error_cnt++;
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    // One four-bit frame: writes c, leaves the fault word in rd
    task automatic frame(input logic [3:0] c);
        u_host.xfer(4, {4'h0, c}, rd);
        wt(10);
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic t_reset;
        chk("gates after reset", fet_drive_out, 4'h0);
        chk("oe idle", {3'h0, serial_out_oe}, 4'h0);
        chk("flag idle", {3'h0, fault_flag_n_oe}, 4'h0);
    endtask
    task automatic t_write;
        frame(4'hA);
        chk("gates A", fet_drive_out, 4'hA);
        frame(4'h5);
        chk("gates 5", fet_drive_out, 4'h5);
        chk("clean word", rd[3:0], 4'h0);
    endtask
    task automatic t_cascade;
        u_host.xfer(8, 8'h3C, rd);
        wt(10);
        chk("cascade faults", rd[7:4], 4'h0);
        chk("cascade pass", rd[3:0], 4'h3);
        chk("cascade gates", fet_drive_out, 4'hC);
    endtask
    task automatic t_direct;
        frame(4'h0);
        direct_channel_in = 4'h9;
        wt(6);
        chk("direct gates", fet_drive_out, 4'h9);
        frame(4'h3);
        chk("or of both", fet_drive_out, 4'hB);
        direct_channel_in = 4'h0;
        frame(4'h0);
    endtask
    task automatic t_short;
        short_m = 4'h1;
        direct_channel_in = 4'h1;
        wt(MSK + DG + 15);
        chk("tripped gate", fet_drive_out, 4'h0);
        chk("short flag", {3'h0, fault_flag_n_oe}, 4'h1);
        frame(4'h0);
        chk("short word", rd[3:0], 4'h1);
        short_m = 4'h0;
        wt(MSK);
        chk("still latched", {3'h0, fault_flag_n_oe}, 4'h1);
        direct_channel_in = 4'h0;
        wt(6);
        direct_channel_in = 4'h1;
        wt(6);
        chk("re-enabled", fet_drive_out, 4'h1);
        chk("flag cleared", {3'h0, fault_flag_n_oe}, 4'h0);
        frame(4'h0);
        chk("word cleared", rd[3:0], 4'h0);
        direct_channel_in = 4'h0;
    endtask
    task automatic t_open;
        open_m = 4'h2;
        wt(MSK + 10);
        chk("open flag", {3'h0, fault_flag_n_oe}, 4'h1);
        u_host.xfer(2, 8'h03, rd);
        wt(10);
        chk("open word", rd[3:0], 4'h0);
        // Two clocks only: leftover fault bits become commands
        chk("short frame", fet_drive_out, 4'hB);
        chk("open while on", {3'h0, fault_flag_n_oe}, 4'h0);
        open_m = 4'h0;
        frame(4'h0);
        wt(MSK + 10);
        frame(4'h0);
        chk("absent fault", rd[3:0], 4'h0);
    endtask
    task automatic t_battery;
        frame(4'hF);
        over_battery_in = 1'b1;
        wt(6);
        chk("battery gates", fet_drive_out, 4'h0);
        chk("battery flag", {3'h0, fault_flag_n_oe}, 4'h1);
        frame(4'hF);
        chk("battery word", rd[3:0], 4'h0);
        over_battery_in = 1'b0;
        wt(MSK + 10);
        chk("battery gone", fet_drive_out, 4'hF);
        chk("battery flag gone", {3'h0, fault_flag_n_oe}, 4'h0);
    endtask
    task automatic t_retry;
        int w;
        frame(4'h0);
        chk("retry pins", {soe_r, flag_r, so_r, 1'b0}, 4'h0);
        short_r = 1'b1;
        direct_channel_in = 4'h1;
        wt(MSK + DG + 15);
        chk("retry trip", fet_r, 4'h0);
        chk("retry flag", {3'h0, flag_r_oe}, 4'h1);
        w = 0;
        while (fet_r[0] !== 1'b1 && w < RPER + 100) begin
            wt(1);
            w++;
        end
        chk("retry pulse", {3'h0, fet_r[0]}, 4'h1);
        w = 0;
        while (fet_r[0] === 1'b1 && w < 100) begin
            wt(1);
            w++;
        end
        chk("pulse width", {3'h0, w == RPULSE}, 4'h1);
        // Short goes away while the gate rests; the next pulse clears it
        short_r = 1'b0;
        wt(RPER + 100);
        chk("retry cleared", fet_r, 4'h1);
        chk("retry flag gone", {3'h0, flag_r_oe}, 4'h0);
        direct_channel_in = 4'h0;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        #2;
        rst = 1'b0;
        wt(3);
        t_reset();
        t_write();
        t_cascade();
        t_direct();
        t_short();
        t_open();
        t_battery();
        t_retry();
        close_out();
    end
endmodule
